/* logic/fsp_top.sv */
// Flash self-program sequencer: table access, holding buffer, timed ops
// Functional notes
// - Target address is table page low byte joined to 16-bit EA.
// - Low table ops reach bits 15..0, word or byte mode.
// - High table ops reach bits 23..16, word or byte mode.
// - Rows hold 64 words; a row is the program unit.
// - Page erase clears eight rows; program writes a row or word.
// - Pages and rows are aligned from start of program memory.
// - Buffer holds 64 words loaded in order from one aligned group.
// - Table write only fills the buffer and takes two cycles.
// - The core is stalled while an operation runs.
// - Duration is a fixed count of oscillator cycles.
// - Go bit starts the operation; hardware clears it on completion.
// - Write permit bit enables program and erase.
// - Error flag sets on bad sequence, abort or invalid go.
// - Erase bit chooses erase or program for next go.
// - Erase decode of the operation field.
// - Program decode of the operation field.
// - Control bits clear only on power-on reset.
// - Key register is 8-bit write-only; upper byte reads zero.
// - Consecutive 0x55 then 0xAA key writes must precede go.
// - Table page top bit selects configuration space.
// - Word-mode high read returns zero in bits 15..8.
// - Constant-window reads are held off during table ops.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module fsp_top
  import fsp_pkg::*;
#(
  parameter int unsigned ROW_CYCLES = FSP_ROW_CLK,
  parameter int unsigned WORD_CYCLES = FSP_WORD_CLK,
  parameter int unsigned PAGE_CYCLES = FSP_PAGE_CLK,
  parameter int unsigned BULK_CYCLES = FSP_BULK_CLK
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sys_reset_req_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire fsp_tbl_req_t tbl_req_i,
  output fsp_tbl_rsp_t tbl_rsp_o,
  output logic cpu_stall_o,
  output logic psv_hold_o,
  output fsp_arr_cmd_t arr_cmd_o,
  output fsp_arr_rd_t arr_rd_o,
  input wire logic [23:0] arr_rd_data_i
);

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef struct packed {
    logic go;
    logic permit;
    logic err;
    logic erase;
    logic [3:0] op_sel;
    logic [7:0] page;
    fsp_key_t key;
    fsp_seq_t seq;
    fsp_op_t run_op;
    logic [FSP_CNT_W-1:0] cnt;
    logic [6:0] step;
    logic [23:0] tgt;
    fsp_tbl_req_t tbl;
    fsp_tbl_rsp_t rsp;
    logic stall;
    logic psv_hold;
    fsp_arr_cmd_t cmd;
    fsp_arr_rd_t rd;
    logic aw_hold;
    logic [11:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fsp_st_t;

  fsp_st_t st_reg;
  fsp_st_t st_next;

  logic [5:0] buf_wr_idx;
  logic [2:0] buf_wr_mask;
  logic [23:0] buf_wr_data;
  logic [5:0] buf_rd_idx;
  logic [23:0] buf_rd_data;

  // Erase bit picks the decode table; unlisted codes run nothing
  function automatic fsp_op_t decode_op(input logic erase,
                                        input logic [3:0] code);
    fsp_op_t r;
    r = FSP_OP_NONE;
    if (erase) begin
      case (code)
        FSP_CODE_BULK: r = FSP_OP_BULK_ERASE;
        FSP_CODE_GSEG: r = FSP_OP_GSEG_ERASE;
        FSP_CODE_SSEG: r = FSP_OP_SSEG_ERASE;
        FSP_CODE_PAGE: r = FSP_OP_PAGE_ERASE;
        FSP_CODE_CFG: r = FSP_OP_CFG_ERASE;
        default: r = FSP_OP_NONE;
      endcase
    end else begin
      case (code)
        FSP_CODE_WORD: r = FSP_OP_WORD_PROG;
        FSP_CODE_ROW: r = FSP_OP_ROW_PROG;
        FSP_CODE_CFG: r = FSP_OP_CFG_PROG;
        default: r = FSP_OP_NONE;
      endcase
    end
    return r;
  endfunction

  // Fixed oscillator-derived length per operation
  function automatic logic [FSP_CNT_W-1:0] op_len(input fsp_op_t op);
    int unsigned n;
    case (op)
      FSP_OP_ROW_PROG: n = ROW_CYCLES;
      FSP_OP_WORD_PROG: n = WORD_CYCLES;
      FSP_OP_CFG_PROG: n = WORD_CYCLES;
      FSP_OP_CFG_ERASE: n = WORD_CYCLES;
      FSP_OP_PAGE_ERASE: n = PAGE_CYCLES;
      FSP_OP_GSEG_ERASE: n = PAGE_CYCLES;
      FSP_OP_SSEG_ERASE: n = PAGE_CYCLES;
      FSP_OP_BULK_ERASE: n = BULK_CYCLES;
      default: n = 1;
    endcase
    return n[FSP_CNT_W-1:0];
  endfunction

  function automatic logic [15:0] ctrl_word(input fsp_st_t s);
    logic [15:0] v;
    v = FSP_CTRL_RST;
    v[FSP_CTRL_GO_BIT] = s.go;
    v[FSP_CTRL_PERMIT_BIT] = s.permit;
    v[FSP_CTRL_ERR_BIT] = s.err;
    v[FSP_CTRL_ERASE_BIT] = s.erase;
    v[FSP_CTRL_OP_LSB +: 4] = s.op_sel;
    return v;
  endfunction

  fsp_hold_buf u_hold_buf (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .wr_idx_i(buf_wr_idx),
    .wr_mask_i(buf_wr_mask),
    .wr_data_i(buf_wr_data),
    .rd_idx_i(buf_rd_idx),
    .rd_data_o(buf_rd_data)
  );

  // Pending table write lands in the buffer only, never the array
  always_comb begin
    buf_wr_idx = st_reg.tbl.ea[6:1];
    buf_wr_mask = 3'b000;
    buf_wr_data = {st_reg.tbl.wdata[7:0], st_reg.tbl.wdata};
    if (st_reg.tbl.valid && st_reg.tbl.write) begin
      if (!st_reg.tbl.high) begin
        if (!st_reg.tbl.byte_mode) begin
          buf_wr_mask = 3'b011;
        end else begin
          buf_wr_data = {3{st_reg.tbl.wdata[7:0]}};
          buf_wr_mask = st_reg.tbl.ea[0] ? 3'b010 : 3'b001;
        end
      end else begin
        // Phantom byte writes are dropped
        buf_wr_mask = (st_reg.tbl.byte_mode && st_reg.tbl.ea[0]) ?
                      3'b000 : 3'b100;
      end
    end
  end

  always_comb begin
    logic [23:0] row_base;
    logic [15:0] cw;
    logic [15:0] rd16;
    logic go_req;
    fsp_op_t nop;
    row_base = 24'h000000;
    cw = 16'h0000;
    rd16 = 16'h0000;
    go_req = 1'b0;
    nop = FSP_OP_NONE;
    st_next = st_reg;
    st_next.rsp.done = 1'b0;
    st_next.cmd.valid = 1'b0;
    st_next.rd.valid = 1'b0;
    buf_rd_idx = st_reg.step[5:0];

    // Table access, second cycle finishes it
    if (st_reg.tbl.valid) begin
      st_next.tbl.valid = 1'b0;
      st_next.rsp.done = 1'b1;
      if (st_reg.tbl.write) begin
        st_next.tgt = {st_reg.page, st_reg.tbl.ea};
      end else if (!st_reg.tbl.high) begin
        rd16 = arr_rd_data_i[15:0];
        if (st_reg.tbl.byte_mode) begin
          rd16 = st_reg.tbl.ea[0] ? {8'h00, rd16[15:8]} :
                                    {8'h00, rd16[7:0]};
        end
        st_next.rsp.rdata = rd16;
      end else if (st_reg.tbl.byte_mode && st_reg.tbl.ea[0]) begin
        st_next.rsp.rdata = 16'h0000;
      end else begin
        st_next.rsp.rdata = {8'h00, arr_rd_data_i[23:16]};
      end
    end else if (tbl_req_i.valid && st_reg.seq == FSP_SEQ_IDLE) begin
      st_next.tbl = tbl_req_i;
      if (!tbl_req_i.write) begin
        st_next.rd.valid = 1'b1;
        st_next.rd.cfg_space = st_reg.page[FSP_PAGE_SPACE_BIT];
        st_next.rd.addr = {st_reg.page, tbl_req_i.ea[15:1], 1'b0};
      end
    end
    st_next.psv_hold = st_next.tbl.valid;

    // Write address and data are taken in either order
    if (s_axi_awvalid_i && st_reg.awready) begin
      st_next.aw_hold = 1'b1;
      st_next.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st_reg.wready) begin
      st_next.w_hold = 1'b1;
      st_next.w_data = s_axi_wdata_i;
      st_next.w_strb = s_axi_wstrb_i;
    end
    if (st_reg.bvalid && s_axi_bready_i) begin
      st_next.bvalid = 1'b0;
    end

    if (st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid) begin
      st_next.aw_hold = 1'b0;
      st_next.w_hold = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      // Every register write other than a good key step drops the unlock
      st_next.key = FSP_KEY_IDLE;
      case ({st_reg.aw_addr[11:2], 2'b00})
        FSP_OFF_KEY: begin
          if (st_reg.w_strb[0]) begin
            if (st_reg.w_data[7:0] == FSP_KEY_FIRST) begin
              st_next.key = FSP_KEY_HALF;
            end else if (st_reg.w_data[7:0] == FSP_KEY_SECOND &&
                         st_reg.key == FSP_KEY_HALF) begin
              st_next.key = FSP_KEY_OPEN;
            end
          end
        end
        FSP_OFF_PAGE: begin
          if (st_reg.w_strb[0]) begin
            st_next.page = st_reg.w_data[7:0];
          end
        end
        FSP_OFF_CTRL: begin
          if (st_reg.seq == FSP_SEQ_IDLE) begin
            if (st_reg.w_strb[0]) begin
              st_next.erase = st_reg.w_data[FSP_CTRL_ERASE_BIT];
              st_next.op_sel = st_reg.w_data[FSP_CTRL_OP_LSB +: 4];
            end
            if (st_reg.w_strb[1]) begin
              st_next.permit = st_reg.w_data[FSP_CTRL_PERMIT_BIT];
              st_next.err = st_reg.w_data[FSP_CTRL_ERR_BIT];
              go_req = st_reg.w_data[FSP_CTRL_GO_BIT];
            end
          end
        end
        default: st_next.bresp = RESP_DECERR;
      endcase
    end

    // Go is honoured only after the unlock and with writes permitted
    if (go_req) begin
      if (st_reg.key == FSP_KEY_OPEN && st_next.permit) begin
        nop = decode_op(st_next.erase, st_next.op_sel);
        st_next.go = 1'b1;
        st_next.seq = FSP_SEQ_RUN;
        st_next.run_op = nop;
        st_next.cnt = op_len(nop);
        st_next.step = 7'h00;
        st_next.stall = 1'b1;
      end else begin
        st_next.err = 1'b1;
      end
    end

    // Timed operation
    if (st_reg.seq == FSP_SEQ_RUN) begin
      row_base = {st_reg.tgt[23:FSP_ROW_ADDR_BITS],
                  {FSP_ROW_ADDR_BITS{1'b0}}};
      st_next.cmd.op = st_reg.run_op;
      st_next.cmd.cfg_space = st_reg.tgt[23];
      if (st_reg.run_op == FSP_OP_ROW_PROG) begin
        if (st_reg.step < 7'(FSP_ROW_WORDS)) begin
          st_next.cmd.valid = 1'b1;
          st_next.cmd.addr = row_base | {17'h00000, st_reg.step[5:0], 1'b0};
          st_next.cmd.data = buf_rd_data;
          st_next.step = st_reg.step + 7'h01;
        end
      end else if (st_reg.run_op != FSP_OP_NONE && st_reg.step == 7'h00) begin
        st_next.step = 7'h01;
        st_next.cmd.valid = 1'b1;
        st_next.cmd.addr = st_reg.tgt;
        if (st_reg.run_op == FSP_OP_WORD_PROG) begin
          buf_rd_idx = st_reg.tgt[6:1];
          st_next.cmd.data = buf_rd_data;
        end else if (st_reg.run_op == FSP_OP_PAGE_ERASE) begin
          st_next.cmd.addr = {st_reg.tgt[23:FSP_PAGE_ADDR_BITS],
                              {FSP_PAGE_ADDR_BITS{1'b0}}};
        end else begin
          st_next.cmd.data = buf_rd_data;
        end
      end
      // Hardware clears go when the count runs out
      if (st_reg.cnt <= FSP_CNT_W'(1)) begin
        st_next.seq = FSP_SEQ_IDLE;
        st_next.go = 1'b0;
        st_next.stall = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt - FSP_CNT_W'(1);
      end
    end

    // Warm reset keeps control bits but aborts and reports a cut-short op
    if (sys_reset_req_i) begin
      if (st_reg.seq == FSP_SEQ_RUN) begin
        st_next.err = 1'b1;
      end
      st_next.seq = FSP_SEQ_IDLE;
      st_next.go = 1'b0;
      st_next.stall = 1'b0;
      st_next.key = FSP_KEY_IDLE;
      st_next.tbl.valid = 1'b0;
      st_next.psv_hold = 1'b0;
      st_next.cmd.valid = 1'b0;
    end

    // Reads answer one cycle after the address is taken
    if (st_reg.rvalid && s_axi_rready_i) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      cw = ctrl_word(st_reg);
      case ({s_axi_araddr_i[11:2], 2'b00})
        FSP_OFF_CTRL: st_next.rdata = {16'h0000, cw};
        FSP_OFF_KEY: st_next.rdata = 32'h00000000;
        FSP_OFF_PAGE: st_next.rdata = {24'h000000, st_reg.page};
        default: begin
          st_next.rdata = 32'h00000000;
          st_next.rresp = RESP_DECERR;
        end
      endcase
    end
    st_next.arready = !st_next.rvalid;
    st_next.awready = !st_next.aw_hold && !st_next.bvalid;
    st_next.wready = !st_next.w_hold && !st_next.bvalid;
  end

  // Power-on reset is the only reset of the control bits
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.page <= FSP_PAGE_RST;
      st_reg.key <= FSP_KEY_IDLE;
      st_reg.seq <= FSP_SEQ_IDLE;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready_o = st_reg.awready;
  assign s_axi_wready_o = st_reg.wready;
  assign s_axi_bvalid_o = st_reg.bvalid;
  assign s_axi_bresp_o = st_reg.bresp;
  assign s_axi_arready_o = st_reg.arready;
  assign s_axi_rvalid_o = st_reg.rvalid;
  assign s_axi_rdata_o = st_reg.rdata;
  assign s_axi_rresp_o = st_reg.rresp;
  assign tbl_rsp_o = st_reg.rsp;
  assign cpu_stall_o = st_reg.stall;
  assign psv_hold_o = st_reg.psv_hold;
  assign arr_cmd_o = st_reg.cmd;
  assign arr_rd_o = st_reg.rd;

endmodule

/* logic/fsp_pkg.sv */
// Shared constants, types and helpers of the flash self-program sequencer
package fsp_pkg;

  // Clock rates and operation lengths in oscillator cycles
  localparam int unsigned FSP_CLK_HZ = 25_000_000;
  localparam int unsigned FSP_RC_HZ = 7_370_000;
  localparam int unsigned FSP_ROW_RC_CYC = 11064;
  localparam int unsigned FSP_WORD_RC_CYC = 400;
  localparam int unsigned FSP_PAGE_RC_CYC = 11064;
  localparam int unsigned FSP_BULK_RC_CYC = 22128;

  // Oscillator cycles to system clocks, rounded up, at least one
  function automatic int unsigned fsp_rc_to_clk(input int unsigned rc);
    longint unsigned prod;
    longint unsigned res;
    prod = longint'(rc) * longint'(FSP_CLK_HZ);
    res = (prod + longint'(FSP_RC_HZ) - 1) / longint'(FSP_RC_HZ);
    if (res == 0) begin
      res = 1;
    end
    return int'(res);
  endfunction

  localparam int unsigned FSP_ROW_CLK = fsp_rc_to_clk(FSP_ROW_RC_CYC);
  localparam int unsigned FSP_WORD_CLK = fsp_rc_to_clk(FSP_WORD_RC_CYC);
  localparam int unsigned FSP_PAGE_CLK = fsp_rc_to_clk(FSP_PAGE_RC_CYC);
  localparam int unsigned FSP_BULK_CLK = fsp_rc_to_clk(FSP_BULK_RC_CYC);
  localparam int FSP_CNT_W = 20;

  // Register byte offsets
  localparam logic [11:0] FSP_OFF_CTRL = 12'h000;
  localparam logic [11:0] FSP_OFF_KEY = 12'h004;
  localparam logic [11:0] FSP_OFF_PAGE = 12'h008;

  // Control register fields
  localparam int FSP_CTRL_GO_BIT = 15;
  localparam int FSP_CTRL_PERMIT_BIT = 14;
  localparam int FSP_CTRL_ERR_BIT = 13;
  localparam int FSP_CTRL_ERASE_BIT = 6;
  localparam int FSP_CTRL_OP_LSB = 0;
  localparam logic [15:0] FSP_CTRL_RST = 16'h0000;
  localparam logic [7:0] FSP_PAGE_RST = 8'h00;
  localparam int FSP_PAGE_SPACE_BIT = 7;

  // Unlock key values
  localparam logic [7:0] FSP_KEY_FIRST = 8'h55;
  localparam logic [7:0] FSP_KEY_SECOND = 8'hAA;

  // Operation field codes
  localparam logic [3:0] FSP_CODE_BULK = 4'hF;
  localparam logic [3:0] FSP_CODE_GSEG = 4'hD;
  localparam logic [3:0] FSP_CODE_SSEG = 4'hC;
  localparam logic [3:0] FSP_CODE_WORD = 4'h3;
  localparam logic [3:0] FSP_CODE_PAGE = 4'h2;
  localparam logic [3:0] FSP_CODE_ROW = 4'h1;
  localparam logic [3:0] FSP_CODE_CFG = 4'h0;

  // Array geometry, addresses count two per instruction word
  localparam int FSP_ROW_WORDS = 64;
  localparam int FSP_ROW_ADDR_BITS = 7;
  localparam int FSP_PAGE_ADDR_BITS = 10;
  localparam logic [23:0] FSP_ERASED_WORD = 24'hFFFFFF;

  typedef enum logic [3:0] {
    FSP_OP_NONE = 4'b0000,
    FSP_OP_ROW_PROG = 4'b0001,
    FSP_OP_WORD_PROG = 4'b0010,
    FSP_OP_CFG_PROG = 4'b0011,
    FSP_OP_PAGE_ERASE = 4'b0100,
    FSP_OP_BULK_ERASE = 4'b0101,
    FSP_OP_GSEG_ERASE = 4'b0110,
    FSP_OP_SSEG_ERASE = 4'b0111,
    FSP_OP_CFG_ERASE = 4'b1000
  } fsp_op_t;

  typedef enum logic [1:0] {
    FSP_KEY_IDLE = 2'b00,
    FSP_KEY_HALF = 2'b01,
    FSP_KEY_OPEN = 2'b10
  } fsp_key_t;

  typedef enum logic [1:0] {
    FSP_SEQ_IDLE = 2'b00,
    FSP_SEQ_RUN = 2'b01
  } fsp_seq_t;

  // Table instruction from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic high;
    logic byte_mode;
    logic [15:0] ea;
    logic [15:0] wdata;
  } fsp_tbl_req_t;

  typedef struct packed {
    logic done;
    logic [15:0] rdata;
  } fsp_tbl_rsp_t;

  // Command to the flash array macro
  typedef struct packed {
    logic valid;
    fsp_op_t op;
    logic cfg_space;
    logic [23:0] addr;
    logic [23:0] data;
  } fsp_arr_cmd_t;

  typedef struct packed {
    logic valid;
    logic cfg_space;
    logic [23:0] addr;
  } fsp_arr_rd_t;

endpackage

/* logic/fsp_hold_buf.sv */
// Row-wide holding buffer with per-byte write enables
`timescale 1ns/100ps
module fsp_hold_buf
  import fsp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] wr_idx_i,
  input wire logic [2:0] wr_mask_i,
  input wire logic [23:0] wr_data_i,
  input wire logic [5:0] rd_idx_i,
  output logic [23:0] rd_data_o
);

  typedef struct packed {
    logic [FSP_ROW_WORDS-1:0][23:0] word;
  } fsp_buf_st_t;

  fsp_buf_st_t st_reg;
  fsp_buf_st_t st_next;

  always_comb begin
    st_next = st_reg;
    for (int b = 0; b < 3; b++) begin
      if (wr_mask_i[b]) begin
        st_next.word[wr_idx_i][b*8 +: 8] = wr_data_i[b*8 +: 8];
      end
    end
  end

  // Unloaded slots hold the erased pattern
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= {FSP_ROW_WORDS{FSP_ERASED_WORD}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data_o = st_reg.word[rd_idx_i];

endmodule

/* tb/fsp_top_asserts.sv */
// Assertions on the sequencer's ports
`timescale 1ns/100ps
module fsp_top_asserts
  import fsp_pkg::*;
#(
  parameter int unsigned ROW_CYCLES = FSP_ROW_CLK
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sys_reset_req_i,
  input wire fsp_tbl_req_t tbl_req_i,
  input wire fsp_tbl_rsp_t tbl_rsp_o,
  input wire logic cpu_stall_o,
  input wire logic psv_hold_o,
  input wire fsp_arr_cmd_t arr_cmd_o,
  input wire fsp_arr_rd_t arr_rd_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic stall_q;
  logic row_seen;
  logic [19:0] run_len;
  wire tbl_go = tbl_req_i.valid && !cpu_stall_o && !psv_hold_o
    && !sys_reset_req_i;
  wire row_cmd = arr_cmd_o.valid && arr_cmd_o.op == FSP_OP_ROW_PROG;
  // Stall length, held after it ends
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stall_q <= 1'b0;
      row_seen <= 1'b0;
      run_len <= 20'h00000;
    end else begin
      stall_q <= cpu_stall_o;
      if (cpu_stall_o && !stall_q)
        run_len <= 20'h00001;
      else if (cpu_stall_o)
        run_len <= run_len + 20'h00001;
      if (row_cmd)
        row_seen <= 1'b1;
      else if (cpu_stall_o && !stall_q)
        row_seen <= 1'b0;
    end
  end
  chk_tbl_latency: assert property (tbl_go |=> psv_hold_o ##1 tbl_rsp_o.done)
    else $error("table access late");
  chk_high_phantom: assert property (tbl_go && !tbl_req_i.write
    && tbl_req_i.high && !tbl_req_i.byte_mode |-> ##2
    tbl_rsp_o.rdata[15:8] == 8'h00)
    else $error("phantom byte nonzero");
  chk_psv_held: assert property (arr_rd_o.valid |-> psv_hold_o)
    else $error("array read without hold");
  chk_stall_refuse: assert property (cpu_stall_o && $past(cpu_stall_o)
    |-> !tbl_rsp_o.done)
    else $error("table access while stalled");
  chk_cmd_in_run: assert property (arr_cmd_o.valid |-> cpu_stall_o)
    else $error("array command outside run");
  chk_row_start: assert property (row_cmd && !$past(arr_cmd_o.valid)
    |-> arr_cmd_o.addr[6:0] == 7'h00)
    else $error("row program not row aligned");
  chk_row_step: assert property (row_cmd && arr_cmd_o.addr[6:1] != 6'h3F
    |=> row_cmd && arr_cmd_o.addr == $past(arr_cmd_o.addr) + 24'h000002)
    else $error("row program burst broken");
  chk_page_align: assert property (arr_cmd_o.valid &&
    arr_cmd_o.op == FSP_OP_PAGE_ERASE |-> arr_cmd_o.addr[9:0] == 10'h000)
    else $error("page erase not page aligned");
  chk_row_len: assert property ($fell(cpu_stall_o) && row_seen
    |-> run_len == 20'(ROW_CYCLES))
    else $error("row program length wrong");
  cover property (row_cmd);
  cover property (arr_cmd_o.valid && arr_cmd_o.op == FSP_OP_PAGE_ERASE);
  cover property (tbl_rsp_o.done);
endmodule

bind fsp_top fsp_top_asserts #(.ROW_CYCLES(ROW_CYCLES)) fsp_top_asserts_inst (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .sys_reset_req_i(sys_reset_req_i),
  .tbl_req_i(tbl_req_i),
  .tbl_rsp_o(tbl_rsp_o),
  .cpu_stall_o(cpu_stall_o),
  .psv_hold_o(psv_hold_o),
  .arr_cmd_o(arr_cmd_o),
  .arr_rd_o(arr_rd_o)
);

/* tb/fsp_array_model.sv */
// Behavioural flash array model
`timescale 1ns/100ps
module fsp_array_model
  import fsp_pkg::*;
(
  input wire logic mclk_i,
  input wire fsp_arr_cmd_t cmd_i,
  input wire fsp_arr_rd_t rd_i,
  output logic [23:0] rd_data_o
);
  logic [23:0] mem [logic [24:0]];
  int ncmd = 0;
  fsp_op_t last_op = FSP_OP_NONE;
  logic [24:0] last_rd = 25'h0000000;
  always @(posedge mclk_i) begin
    if (cmd_i.valid) begin
      ncmd++;
      last_op = cmd_i.op;
      // Any erase wipes the whole model
      if (cmd_i.op inside {FSP_OP_PAGE_ERASE, FSP_OP_BULK_ERASE,
          FSP_OP_GSEG_ERASE, FSP_OP_SSEG_ERASE, FSP_OP_CFG_ERASE})
        mem.delete();
      else
        mem[{cmd_i.cfg_space, cmd_i.addr}] = cmd_i.data;
    end
  end
  // Read data stands while valid
  always @* begin
    rd_data_o = 24'h3C3C3C;
    if (rd_i.valid) begin
      last_rd = {rd_i.cfg_space, rd_i.addr};
      rd_data_o = mem.exists(last_rd) ? mem[last_rd] : FSP_ERASED_WORD;
    end
  end
endmodule

/* tb/flash_self_program_sequencer_test.sv */
// Bench for the flash self-program sequencer
`timescale 1ns/100ps
module flash_self_program_sequencer_test
  import fsp_pkg::*;
;
  // Row: ctrl word, expected op code nibble
  localparam logic [19:0] OPS [16] = '{20'h404F5, 20'h404D6, 20'h404C7,
    20'h40424, 20'h40408, 20'h40430, 20'h40410, 20'h400F0, 20'h400D0,
    20'h400C0, 20'h40020, 20'h40003, 20'h40032, 20'h00420, 20'h40450,
    20'h40070};
  logic mclk_i, rst_n_i = 1'b0, srst = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000, bus_d;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic [1:0] bus_r;
  logic [3:0] wstrb = 4'hF;
  logic rdy = 1'b1;
  fsp_tbl_req_t treq = '0;
  fsp_tbl_rsp_t trsp;
  fsp_arr_cmd_t acmd;
  fsp_arr_rd_t ard;
  wire [23:0] adata;
  wire stall, constant_window_view;
  logic tdone;
  logic [15:0] tdat, ex;
  int n0, error_cnt = 0, cmp_count = 0;

  fsp_top #(.ROW_CYCLES(80), .WORD_CYCLES(10), .PAGE_CYCLES(10),
    .BULK_CYCLES(10)) fsp_top_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .sys_reset_req_i(srst), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(rdy),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rdy),
    .tbl_req_i(treq), .tbl_rsp_o(trsp), .cpu_stall_o(stall),
    .psv_hold_o(constant_window_view), .arr_cmd_o(acmd), .arr_rd_o(ard),
    .arr_rd_data_i(adata));
  fsp_array_model fsp_array_model_inst (.mclk_i(mclk_i), .cmd_i(acmd),
    .rd_i(ard), .rd_data_o(adata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid) begin
        bus_r = bresp;
        break;
      end
    end
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid) begin
        bus_d = rdata;
        bus_r = rresp;
        break;
      end
    end
  endtask
  // Dropped request leaves tdone low
  task automatic tbl(input logic w, input logic h, input logic b,
      input logic [15:0] ea, input logic [15:0] wd);
    treq <= '{1'b1, w, h, b, ea, wd};
    @(posedge mclk_i);
    treq.valid <= 1'b0;
    tdone = 1'b0;
    repeat (4) begin
      @(posedge mclk_i);
      if (trsp.done) begin
        tdone = 1'b1;
        tdat = trsp.rdata;
      end
    end
  endtask
  task automatic go(input logic [15:0] s);
    wr(FSP_OFF_CTRL, {16'h0000, s});
    wr(FSP_OFF_KEY, {24'h000000, FSP_KEY_FIRST});
    wr(FSP_OFF_KEY, {24'h000000, FSP_KEY_SECOND});
    wr(FSP_OFF_CTRL, {16'h0000, s | 16'h8000});
  endtask
  task automatic wait_go();
    int n = 0;
    do begin
      rd(FSP_OFF_CTRL);
      n++;
    end while (bus_d[15] && n < 500);
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    #2000000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    for (int i = 0; i < 64; i++) begin
      tbl(1'b1, 1'b0, 1'b0, 16'h0100 + 16'(2 * i), 16'hA000 + 16'(i));
      tbl(1'b1, 1'b1, 1'b0, 16'h0100 + 16'(2 * i), 16'h0010 + 16'(i));
    end
    go(16'h4001);
    tbl(1'b0, 1'b0, 1'b0, 16'h0100, 16'h0000);
    check(32'(tdone), 32'h00000000);
    wait_go();
    check(bus_d, 32'h00004001);
    tbl(1'b0, 1'b0, 1'b0, 16'h010A, 16'h0000);
    check(32'(tdat), 32'h0000A005);
    tbl(1'b0, 1'b0, 1'b1, 16'h010B, 16'h0000);
    check(32'(tdat), 32'h000000A0);
    tbl(1'b0, 1'b1, 1'b0, 16'h010A, 16'h0000);
    check(32'(tdat), 32'h00000015);
    tbl(1'b0, 1'b1, 1'b1, 16'h010B, 16'h0000);
    check(32'(tdat), 32'h00000000);
    foreach (OPS[i]) begin
      n0 = fsp_array_model_inst.ncmd;
      go(OPS[i][19:4]);
      wait_go();
      ex = OPS[i][19:4] | (OPS[i][18] ? 16'h0000 : 16'h2000);
      check(bus_d, {16'h0000, ex});
      check(32'(fsp_array_model_inst.ncmd - n0), 32'(OPS[i][3:0] != 4'h0));
      if (OPS[i][3:0] != 4'h0)
        check(32'(fsp_array_model_inst.last_op), 32'(OPS[i][3:0]));
    end
    // Broken unlock: bad key, then stray write
    for (int k = 0; k < 2; k++) begin
      n0 = fsp_array_model_inst.ncmd;
      wr(FSP_OFF_CTRL, 32'h00004042);
      wr(FSP_OFF_KEY, {24'h000000, FSP_KEY_FIRST});
      wr(k == 0 ? FSP_OFF_KEY : FSP_OFF_PAGE, 32'h00000000);
      wr(FSP_OFF_KEY, {24'h000000, FSP_KEY_SECOND});
      wr(FSP_OFF_CTRL, 32'h0000C042);
      rd(FSP_OFF_CTRL);
      check(bus_d, 32'h00006042);
      check(32'(fsp_array_model_inst.ncmd - n0), 32'h00000000);
    end
    wr(FSP_OFF_PAGE, 32'h00012381);
    rd(FSP_OFF_PAGE);
    check(bus_d, 32'h00000081);
    tbl(1'b0, 1'b0, 1'b0, 16'h0246, 16'h0000);
    check(32'(fsp_array_model_inst.last_rd), 32'h01810246);
    rd(FSP_OFF_KEY);
    check(bus_d, 32'h00000000);
    wr(12'h00C, 32'hFFFFFFFF);
    check(32'(bus_r), 32'h00000003);
    rd(12'h00C);
    check({bus_d[29:0], bus_r}, 32'h00000003);
    go(16'h404F);
    srst <= 1'b1;
    @(posedge mclk_i);
    srst <= 1'b0;
    rd(FSP_OFF_CTRL);
    check(bus_d, 32'h0000604F);
    check(32'(stall), 32'h00000000);
    srst <= 1'b1;
    @(posedge mclk_i);
    srst <= 1'b0;
    rd(FSP_OFF_CTRL);
    check(bus_d, 32'h0000604F);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(FSP_OFF_CTRL);
    check(bus_d, 32'h00000000);
    end_of_test();
  end
endmodule
